// ---- verilog/mbs_pkg.sv ----
// Overview of operation
// [RL1] Debounce trigger pin at fine or coarse tap.
// [RL2] Internal trigger follows pin, inverted when edge zero.
// [RL3] Trigger path owns its own edge selection.
// [RL4] Interrupt every tenth second or every second.
// [RL5] Measurement type matters only under pin control.
// [RL6] Pin control: run enable only arms counter.
// [RL7] Pulse width: rise starts, fall stops, clears enable.
// [RL8] Start/stop: alternate rising edges start and stop.
// [RL9] CPU control: count while run enable set.
// [RL10] Edge select ignored under CPU control.
// [RL11] Pin takeover: next rise stops running counter.
// [RL12] Software prepares start condition before pin takeover.
// [RL13] Clear bit zeroes count, self-clears, reads zero.
// [RL14] Reset stops counter and clears count.
// [RL15] Software clears, configures, then sets run enable.
// [RL16] Software reads full value only when stopped.
// [RL17] Count shown as three BCD digit registers.
// [RL18] Control two: seconds flag plus three settings.
// [RL19] Seconds flag set at 999, cleared on read.
// [RL20] Count advances one per millisecond, decimal carries.
// [RL21] Wrap 999 to 000; interrupt per rate.
package mbs_pkg;

   // -------------------------------------------------------------
   // Register map and field positions
   // -------------------------------------------------------------
   localparam logic [7:0] MBS_OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] MBS_OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] MBS_OFS_THOUSANDTHS = 8'h08;
   localparam logic [7:0] MBS_OFS_HUNDREDTHS = 8'h0c;
   localparam logic [7:0] MBS_OFS_TENTHS = 8'h10;
   localparam int MBS_BIT_RUN_ENABLE = 3;
   localparam int MBS_BIT_PIN_CONTROL = 2;
   localparam int MBS_BIT_MEAS_TYPE = 1;
   localparam int MBS_BIT_COUNTER_CLEAR = 0;
   localparam int MBS_BIT_DEB_RATE = 3;
   localparam int MBS_BIT_EDGE_SEL = 2;
   localparam int MBS_BIT_INT_RATE = 1;
   localparam int MBS_BIT_SECONDS = 0;
   localparam logic [3:0] MBS_RST_DIGIT = 4'h0;
   localparam logic [3:0] MBS_DIGIT_MAX = 4'h9;
   localparam logic [1:0] MBS_RESP_OKAY = 2'h0;
   localparam logic [1:0] MBS_RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int MBS_CLK_PERIOD_NS = 10;
   localparam int MBS_MS_PERIOD_NS = 1000000;
   localparam int MBS_DEB_FINE_NS = 250000;
   localparam int MBS_DEB_COARSE_NS = 4000000;
   localparam int MBS_MS_CYCLES = MBS_MS_PERIOD_NS / MBS_CLK_PERIOD_NS;
   localparam int MBS_DEB_FINE_CYCLES = MBS_DEB_FINE_NS / MBS_CLK_PERIOD_NS;
   localparam int MBS_DEB_COARSE_CYCLES = MBS_DEB_COARSE_NS / MBS_CLK_PERIOD_NS;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef struct packed {
      logic run_enable;
      logic pin_control_select;
      logic measurement_type_select;
   } mbs_ctl_one_t;

   typedef struct packed {
      logic debouncer_rate_select;
      logic trigger_edge_select;
      logic interrupt_rate_select;
   } mbs_ctl_two_t;

   typedef struct packed {
      logic [3:0] tenths;
      logic [3:0] hundredths;
      logic [3:0] thousandths;
   } mbs_bcd_t;

   typedef enum logic [3:0] {
      MBS_IDLE = 4'b0001,
      MBS_ARMED = 4'b0010,
      MBS_PIN_RUN = 4'b0100,
      MBS_CPU_RUN = 4'b1000
   } mbs_state_t;

endpackage

// ---- verilog/mbs_stopwatch.sv ----
`timescale 1ns/1ps
module mbs_stopwatch
   import mbs_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MBS_MS_CYCLES,
   parameter int unsigned DEB_FINE_CYCLES = MBS_DEB_FINE_CYCLES,
   parameter int unsigned DEB_COARSE_CYCLES = MBS_DEB_COARSE_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trigger_pin,
   output logic stopwatch_interrupt_request
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   mbs_ctl_one_t ctl1_reg;
   mbs_ctl_one_t ctl1_next;
   mbs_ctl_two_t ctl2_reg;
   mbs_bcd_t bcd_reg;
   mbs_bcd_t bcd_next;
   mbs_state_t state_reg;
   mbs_state_t state_next;
   logic seconds_flag_reg;
   logic irq_reg;
   logic [31:0] ms_cnt_reg;
   logic [31:0] deb_cnt_reg;
   logic samp_reg;
   logic deb_reg;
   logic trig_prev_reg;
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   wire aw_hs = s_axi_awvalid & awready_reg;
   wire w_hs = s_axi_wvalid & wready_reg;
   wire ar_hs = s_axi_arvalid & arready_reg;
   wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire wr_lane0 = do_write & w_strb_reg[0];
   wire wr_ctl1 = wr_lane0 & (aw_addr_reg == MBS_OFS_CTRL_ONE);
   wire wr_ctl2 = wr_lane0 & (aw_addr_reg == MBS_OFS_CTRL_TWO);
   wire wr_hit = (aw_addr_reg == MBS_OFS_CTRL_ONE) | (aw_addr_reg == MBS_OFS_CTRL_TWO) |
      (aw_addr_reg == MBS_OFS_THOUSANDTHS) | (aw_addr_reg == MBS_OFS_HUNDREDTHS) |
      (aw_addr_reg == MBS_OFS_TENTHS);
   wire rd_ctl2 = ar_hs & (s_axi_araddr == MBS_OFS_CTRL_TWO);
   wire aw_full_next = aw_hs | (aw_full_reg & ~do_write);
   wire w_full_next = w_hs | (w_full_reg & ~do_write);
   // [RL13] Clear strobe only.
   wire counter_clear = wr_ctl1 & w_data_reg[MBS_BIT_COUNTER_CLEAR];

   // Read mux; the clear bit has no storage so it always reads zero.
   logic [3:0] rd_nib;
   logic rd_hit;
   always_comb
   begin
      rd_nib = 4'h0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         MBS_OFS_CTRL_ONE: rd_nib = {ctl1_reg, 1'b0};
         // [RL18] Control two layout.
         MBS_OFS_CTRL_TWO: rd_nib = {ctl2_reg, seconds_flag_reg};
         // [RL17] Digit registers.
         MBS_OFS_THOUSANDTHS: rd_nib = bcd_reg.thousandths;
         MBS_OFS_HUNDREDTHS: rd_nib = bcd_reg.hundredths;
         MBS_OFS_TENTHS: rd_nib = bcd_reg.tenths;
         default: rd_hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   // Address and data are held independently so either may arrive first.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= MBS_RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready_reg <= ~aw_full_next;
         wready_reg <= ~w_full_next;
         if (aw_hs)
            aw_addr_reg <= s_axi_awaddr;
         if (w_hs)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? MBS_RESP_OKAY : MBS_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   // Data is captured at the address handshake, one read in flight.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= MBS_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {28'h0000000, rd_nib};
         rresp_reg <= rd_hit ? MBS_RESP_OKAY : MBS_RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
      else if (!rvalid_reg)
         arready_reg <= 1'b1;
   end

   // ------------------------------------------------------------------
   // Trigger debouncer and edge detect
   // ------------------------------------------------------------------
   // [RL1] Tap select.
   wire [31:0] deb_limit = ctl2_reg.debouncer_rate_select ?
      32'(DEB_COARSE_CYCLES - 1) : 32'(DEB_FINE_CYCLES - 1);
   wire deb_tick = (deb_cnt_reg >= deb_limit);
   // [RL2] Polarity from own edge select.
   wire internal_trigger = ctl2_reg.trigger_edge_select ? deb_reg : ~deb_reg;
   wire trig_rise = internal_trigger & ~trig_prev_reg;
   wire trig_fall = ~internal_trigger & trig_prev_reg;

   // [RL3] Private debounce chain.
   // A new level is taken only when two tap samples agree, so a glitch
   // shorter than one tap period never reaches the mode logic.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         deb_cnt_reg <= 32'h0000_0000;
         samp_reg <= 1'b0;
         deb_reg <= 1'b0;
         trig_prev_reg <= 1'b1;
      end
      else
      begin
         deb_cnt_reg <= deb_tick ? 32'h0000_0000 : deb_cnt_reg + 32'h0000_0001;
         if (deb_tick)
         begin
            samp_reg <= trigger_pin;
            if (samp_reg == trigger_pin)
               deb_reg <= trigger_pin;
         end
         trig_prev_reg <= internal_trigger;
      end
   end

   // ------------------------------------------------------------------
   // Mode state machine
   // ------------------------------------------------------------------
   wire pin_mode = ctl1_reg.pin_control_select;
   wire pulse_mode = ctl1_reg.measurement_type_select;
   wire counting = (state_reg == MBS_PIN_RUN) | (state_reg == MBS_CPU_RUN);
   logic hw_clear_run;

   always_comb
   begin
      state_next = state_reg;
      hw_clear_run = 1'b0;
      if (!ctl1_reg.run_enable)
         state_next = MBS_IDLE;
      else
      begin
         unique case (state_reg)
            MBS_IDLE:
               // [RL6] Arm only.
               // [RL9] CPU start counts at once.
               state_next = pin_mode ? MBS_ARMED : MBS_CPU_RUN;
            MBS_ARMED:
               if (!pin_mode)
                  state_next = MBS_CPU_RUN;
               else if (trig_rise)
                  state_next = MBS_PIN_RUN;
            MBS_PIN_RUN:
               // [RL5] Measurement type used here and in the MBS_CPU_RUN takeover stop.
               if (!pin_mode)
                  state_next = MBS_CPU_RUN;
               else if (pulse_mode & trig_fall)
               begin
                  // [RL7] Falling edge ends pulse.
                  state_next = MBS_IDLE;
                  hw_clear_run = 1'b1;
               end
               else if (!pulse_mode & trig_rise)
                  // [RL8] Stop and rearm.
                  state_next = MBS_ARMED;
            MBS_CPU_RUN:
               // [RL10] Edges ignored unless pin mode.
               // [RL11] Takeover stop on rise.
               if (pin_mode & trig_rise)
               begin
                  state_next = pulse_mode ? MBS_IDLE : MBS_ARMED;
                  hw_clear_run = pulse_mode;
               end
            default: state_next = MBS_IDLE;
         endcase
      end
   end

   // Software writing the enable in the same cycle wins over the hardware clear.
   always_comb
   begin
      ctl1_next = ctl1_reg;
      if (hw_clear_run)
         ctl1_next.run_enable = 1'b0;
      if (wr_ctl1)
         ctl1_next = w_data_reg[MBS_BIT_RUN_ENABLE:MBS_BIT_MEAS_TYPE];
   end

   // ------------------------------------------------------------------
   // Millisecond tick and BCD counter
   // ------------------------------------------------------------------
   wire ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
   wire inc = ms_tick & counting;
   wire d0_max = (bcd_reg.thousandths == MBS_DIGIT_MAX);
   wire d1_max = (bcd_reg.hundredths == MBS_DIGIT_MAX);
   wire d2_max = (bcd_reg.tenths == MBS_DIGIT_MAX);
   wire tenth_step = inc & d0_max & d1_max;
   wire wrap = tenth_step & d2_max;
   wire reach_999 = inc & d1_max & d2_max & (bcd_reg.thousandths == 4'h8);
   // [RL4] Rate select.
   wire int_event = ctl2_reg.interrupt_rate_select ? wrap : tenth_step;

   // [RL20] Decimal carry chain.
   always_comb
   begin
      bcd_next = bcd_reg;
      if (counter_clear)
         bcd_next = {MBS_RST_DIGIT, MBS_RST_DIGIT, MBS_RST_DIGIT};
      else if (inc)
      begin
         bcd_next.thousandths = d0_max ? MBS_RST_DIGIT : bcd_reg.thousandths + 4'h1;
         if (d0_max)
            bcd_next.hundredths = d1_max ? MBS_RST_DIGIT : bcd_reg.hundredths + 4'h1;
         // [RL21] Wraps to zero.
         if (d0_max & d1_max)
            bcd_next.tenths = d2_max ? MBS_RST_DIGIT : bcd_reg.tenths + 4'h1;
      end
   end

   // [RL14] Reset stops and clears.
   // The millisecond prescaler runs freely, so a start lands anywhere within
   // the first millisecond: resolution is one millisecond, as in the device.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ms_cnt_reg <= 32'h0000_0000;
         bcd_reg <= {MBS_RST_DIGIT, MBS_RST_DIGIT, MBS_RST_DIGIT};
         state_reg <= MBS_IDLE;
         ctl1_reg <= '0;
         ctl2_reg <= '0;
         seconds_flag_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
         bcd_reg <= bcd_next;
         state_reg <= state_next;
         ctl1_reg <= ctl1_next;
         if (wr_ctl2)
            ctl2_reg <= w_data_reg[MBS_BIT_DEB_RATE:MBS_BIT_INT_RATE];
         // [RL19] Set wins over read clear.
         seconds_flag_reg <= reach_999 | (seconds_flag_reg & ~rd_ctl2);
         irq_reg <= int_event;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign stopwatch_interrupt_request = irq_reg;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_clear_zeroes: assert property (counter_clear |=> bcd_reg == 12'h000) // [RL13]
      else $error("counter clear did not zero the count");
   a_cpu_start_run: assert property ( // [RL9]
      state_reg == MBS_IDLE && ctl1_reg.run_enable && !pin_mode |=> counting)
      else $error("cpu start did not begin counting");
   a_cpu_stop_halt: assert property ( // [RL9]
      !ctl1_reg.run_enable |=> !counting)
      else $error("counter kept running without run enable");
   a_pin_arm_only: assert property ( // [RL6]
      state_reg == MBS_IDLE && ctl1_reg.run_enable && pin_mode |=> !counting)
      else $error("pin mode started without trigger edge");
   a_pulse_end_clear: assert property ( // [RL7]
      state_reg == MBS_PIN_RUN && ctl1_reg.run_enable && pin_mode && pulse_mode
      && trig_fall && !wr_ctl1 |=> !counting && !ctl1_reg.run_enable)
      else $error("pulse end did not stop and clear run enable");
   a_startstop_keep_run: assert property ( // [RL8]
      state_reg == MBS_PIN_RUN && ctl1_reg.run_enable && pin_mode && !pulse_mode
      && trig_rise && !wr_ctl1 |=> state_reg == MBS_ARMED && ctl1_reg.run_enable)
      else $error("start stop edge did not rearm with run enable kept");
   a_bcd_wrap_zero: assert property ( // [RL21]
      inc && bcd_reg == 12'h999 && !counter_clear |=> bcd_reg == 12'h000)
      else $error("count did not wrap from 999 to 000");
   a_seconds_flag_set: assert property ( // [RL19]
      inc && bcd_reg == 12'h998 && !counter_clear |=> seconds_flag_reg ##1 bcd_reg == 12'h999
      || seconds_flag_reg)
      else $error("seconds flag not set on reaching 999");
   a_irq_rate_match: assert property ( // [RL4]
      irq_reg |-> $past(ctl2_reg.interrupt_rate_select) ? $past(wrap) : $past(tenth_step))
      else $error("interrupt pulse without matching count event");

   c_pulse_measured: cover property (state_reg == MBS_PIN_RUN && pulse_mode && trig_fall);
   c_count_wrap: cover property (wrap);
   c_restart_edge: cover property (state_reg == MBS_ARMED ##[1:1000] state_reg == MBS_PIN_RUN);
   c_takeover_stop: cover property (state_reg == MBS_CPU_RUN && pin_mode && trig_rise);

endmodule

// ---- bench/mbs_pulse_src.sv ----
`timescale 1ns/1ps
// Pulse source on the trigger pin; it drives a push-pull level at all times.
module mbs_pulse_src
(
   input wire logic aclk,
   output logic trigger_pin
);
   initial trigger_pin = 1'b0;

   // One positive pulse, then an idle gap; both are counted in clock cycles.
   task automatic pulse(input int width, input int gap);
      @(posedge aclk);
      trigger_pin <= 1'b1;
      repeat (width) @(posedge aclk);
      trigger_pin <= 1'b0;
      repeat (gap) @(posedge aclk);
   endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
   import mbs_pkg::*;
;
   localparam int MS = 20;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, trigger_pin, stopwatch_interrupt_request;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [33:0] q_exp[$];
   logic [33:0] q_msk[$];
   logic [1:0] q_b[$];
   logic [31:0] rnd = 32'h00018634;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n, w, h;

   // Short counts keep a full second of counting within the run budget.
   mbs_stopwatch #(.MS_CYCLES(MS), .DEB_FINE_CYCLES(2), .DEB_COARSE_CYCLES(4)) u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_pin,
      .stopwatch_interrupt_request);
   mbs_pulse_src u_src (.aclk, .trigger_pin);

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Compare and report
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp_read(input logic [33:0] got, input logic [33:0] e, input logic [33:0] m);
      n_compared++;
      if ((got & m) !== (e & m))
      begin
         fail_count++;
         $display("mismatch at %0t: read %h expected %h", $time, got, e);
      end
   endtask

   task automatic cmp_write(input logic [1:0] got, input logic [1:0] e);
      n_compared++;
      if (got !== e)
      begin
         fail_count++;
         $display("mismatch at %0t: bresp %h expected %h", $time, got, e);
      end
   endtask

   task automatic cmp_cond(input logic ok, input int v);
      n_compared++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: measured %0d out of range", $time, v);
      end
   endtask

   // The monitor takes the oldest note whenever an answer is accepted.
   always @(posedge aclk)
   begin
      if (aresetn && s_axi_rvalid && s_axi_rready)
         cmp_read({s_axi_rresp, s_axi_rdata}, q_exp.pop_front(), q_msk.pop_front());
      if (aresetn && s_axi_bvalid && s_axi_bready)
         cmp_write(s_axi_bresp, q_b.pop_front());
   end

   // A hang ends the run well beyond the longest sequence of about 20000 cycles.
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         $display("mismatch at %0t: timeout", $time);
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Bus tasks; each opens one edge late so a release never meets a new request.
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      q_b.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   // A read with chk low notes a mask of zero and leaves the value in rd_val.
   task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [3:0] e,
                     input logic chk);
      @(posedge aclk);
      q_exp.push_back({r, 28'h0, e});
      q_msk.push_back(chk ? {34{1'b1}} : 34'h0);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd_val = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wait_irq(output int c);
      c = 0;
      do
      begin
         @(posedge aclk);
         c++;
      end
      while (stopwatch_interrupt_request !== 1'b1 && c < 25000);
   endtask

   task automatic digits_zero();
      for (int i = 2; i < 5; i++)
         rd(8'(i * 4), MBS_RESP_OKAY, 4'h0, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd(8'(i * 4), MBS_RESP_OKAY, 4'h0, 1'b1);
      rd(8'h14, MBS_RESP_SLVERR, 4'h0, 1'b1);
      wr(8'h20, 32'hf, MBS_RESP_SLVERR);
      // A write without the low byte lane is answered but changes nothing.
      s_axi_wstrb <= 4'he;
      wr(MBS_OFS_CTRL_TWO, 32'hf, MBS_RESP_OKAY);
      rd(MBS_OFS_CTRL_TWO, MBS_RESP_OKAY, 4'h0, 1'b1);
      s_axi_wstrb <= 4'hf;
      $display("test reset_map done");
      // Clear, configure, then run; edge select must not disturb CPU counting.
      wr(MBS_OFS_CTRL_ONE, 32'h1, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'h0, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_ONE, 32'h8, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'h4, MBS_RESP_OKAY);
      wait_irq(n);
      cmp_cond(n >= 97 * MS && n <= 101 * MS, n);
      wr(MBS_OFS_CTRL_ONE, 32'h0, MBS_RESP_OKAY);
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, 4'h0, 1'b1);
      rd(MBS_OFS_HUNDREDTHS, MBS_RESP_OKAY, 4'h0, 1'b1);
      rd(MBS_OFS_TENTHS, MBS_RESP_OKAY, 4'h1, 1'b1);
      rd(MBS_OFS_CTRL_TWO, MBS_RESP_OKAY, 4'h4, 1'b1);
      $display("test cpu_tenth done");
      wr(MBS_OFS_CTRL_ONE, 32'h1, MBS_RESP_OKAY);
      rd(MBS_OFS_CTRL_ONE, MBS_RESP_OKAY, 4'h0, 1'b1);
      digits_zero();
      wr(MBS_OFS_CTRL_TWO, 32'h2, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_ONE, 32'h8, MBS_RESP_OKAY);
      wait_irq(n);
      cmp_cond(n >= 997 * MS && n <= 1001 * MS, n);
      wr(MBS_OFS_CTRL_ONE, 32'h0, MBS_RESP_OKAY);
      digits_zero();
      rd(MBS_OFS_CTRL_TWO, MBS_RESP_OKAY, 4'h3, 1'b1);
      rd(MBS_OFS_CTRL_TWO, MBS_RESP_OKAY, 4'h2, 1'b1);
      $display("test cpu_second done");
      // Pulse width on a non-inverted trigger with the fine debounce tap.
      wr(MBS_OFS_CTRL_ONE, 32'h1, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'h4, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_ONE, 32'he, MBS_RESP_OKAY);
      repeat (3 * MS) @(posedge aclk);
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, 4'h0, 1'b1);
      rnd = xs(rnd);
      w = 3 + int'(rnd % 32'd6);
      u_src.pulse(w * MS, 2 * MS);
      rd(MBS_OFS_CTRL_ONE, MBS_RESP_OKAY, 4'h6, 1'b1);
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, 4'h0, 1'b0);
      cmp_cond(int'(rd_val) >= w - 1 && int'(rd_val) <= w + 1, int'(rd_val));
      $display("test pulse_width done");
      // Start and stop on an inverted trigger with the coarse debounce tap.
      wr(MBS_OFS_CTRL_ONE, 32'h1, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'h8, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_ONE, 32'hc, MBS_RESP_OKAY);
      rnd = xs(rnd);
      w = 5 + int'(rnd % 32'd10);
      u_src.pulse(3 * MS, w * MS);
      u_src.pulse(3 * MS, 2 * MS);
      rd(MBS_OFS_CTRL_ONE, MBS_RESP_OKAY, 4'hc, 1'b1);
      rd(MBS_OFS_HUNDREDTHS, MBS_RESP_OKAY, 4'h0, 1'b0);
      h = int'(rd_val) * 10;
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, 4'h0, 1'b0);
      h = h + int'(rd_val);
      cmp_cond(h >= w + 2 && h <= w + 4, h);
      $display("test start_stop done");
      // CPU start in pulse mode; toggling edge select makes the rise first.
      wr(MBS_OFS_CTRL_ONE, 32'ha, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'hc, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_TWO, 32'h8, MBS_RESP_OKAY);
      wr(MBS_OFS_CTRL_ONE, 32'he, MBS_RESP_OKAY);
      u_src.pulse(3 * MS, 2 * MS);
      rd(MBS_OFS_CTRL_ONE, MBS_RESP_OKAY, 4'h6, 1'b1);
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, 4'h0, 1'b0);
      repeat (3 * MS) @(posedge aclk);
      rd(MBS_OFS_THOUSANDTHS, MBS_RESP_OKAY, rd_val[3:0], 1'b1);
      $display("test pin_takeover done");
      // A reset in mid-count stops the counter and clears every register.
      wr(MBS_OFS_CTRL_ONE, 32'h8, MBS_RESP_OKAY);
      repeat (15 * MS) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2 * MS) @(posedge aclk);
      for (int i = 0; i < 5; i++)
         rd(8'(i * 4), MBS_RESP_OKAY, 4'h0, 1'b1);
      $display("test mid_reset done");
      report_and_stop();
   end
endmodule
